// File: rtl/scu_consts.svh
/*
 * constants for the sixteen-bit counter unit: register indices, field positions,
 * clock select codes, divider end counts and fixed top values.
 * assumes inclusion by bare name from the package and the design modules.
 */
`ifndef SCU_CONSTS_SVH
`define SCU_CONSTS_SVH

// ****************************************************************
// register indices on the byte-wide processor bus
// ****************************************************************
`define SCU_IDX_CTRL_A      4'h0
`define SCU_IDX_CTRL_B      4'h1
`define SCU_IDX_CNT_LO      4'h2
`define SCU_IDX_CNT_HI      4'h3
`define SCU_IDX_CMP_LO      4'h4
`define SCU_IDX_CMP_HI      4'h5
`define SCU_IDX_CAP_LO      4'h6
`define SCU_IDX_CAP_HI      4'h7
`define SCU_IDX_FLAGS       4'h8

// ****************************************************************
// field positions
// ****************************************************************
`define SCU_CSEL_MSB        2
`define SCU_CSEL_LSB        0
`define SCU_WGM_B_MSB       4
`define SCU_WGM_B_LSB       3
`define SCU_WGM_A_MSB       1
`define SCU_WGM_A_LSB       0
`define SCU_WRAP_BIT        0

// ****************************************************************
// reset values and codes
// ****************************************************************
`define SCU_RST_BYTE        8'h00
`define SCU_RST_WORD        16'h0000
`define SCU_CSEL_STOP       3'h0
`define SCU_CSEL_DIV1       3'h1
`define SCU_CSEL_DIV8       3'h2
`define SCU_CSEL_DIV64      3'h3
`define SCU_CSEL_DIV256     3'h4
`define SCU_CSEL_DIV1024    3'h5
`define SCU_CSEL_EXT_FALL   3'h6
`define SCU_CSEL_EXT_RISE   3'h7
`define SCU_DIV8_LAST       10'h007
`define SCU_DIV64_LAST      10'h03f
`define SCU_DIV256_LAST     10'h0ff
`define SCU_DIV1024_LAST    10'h3ff
`define SCU_TOP_8BIT        16'h00ff
`define SCU_TOP_9BIT        16'h01ff
`define SCU_TOP_10BIT       16'h03ff
`define SCU_MAX             16'hffff
`define SCU_BOTTOM          16'h0000
`define SCU_ONE             16'h0001

`endif

// File: rtl/scu_pkg.sv
/*
 * types shared by the sixteen-bit counter unit.
 * assumes scu_consts.svh is on the include path.
 */
`include "scu_consts.svh"

package scu_pkg;

	// processor bus request as seen by the timer
	typedef struct packed {
		logic [3:0] addr;
		logic       rd;
		logic       wr;
		logic [7:0] wdata;
	} scu_bus_req_type;

	// count sequence shapes derived from the mode field
	typedef enum logic [1:0] {
		SCU_SEQ_UP_WRAP  = 2'b00,
		SCU_SEQ_UP_CLEAR = 2'b01,
		SCU_SEQ_UP_DOWN  = 2'b11
	} scu_seq_type;

	// counter status flags
	typedef struct packed {
		logic top;
		logic bottom;
	} scu_ind_type;

endpackage

// File: rtl/scu_clock_select.sv
/*
 * count clock select: turns the clock select field into a one-cycle step
 * enable from an internal divider or a synchronised external pin edge.
 * assumes a single system clock; the external pin is asynchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"

module scu_clock_select
	import scu_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic       rst,
	input  wire logic [2:0] clock_source_select,
	input  wire logic       ext_pin,
	output logic            count_clock
);

	logic [9:0] div_r;
	logic       pin_meta_r;
	logic       pin_sync_r;
	logic       pin_prev_r;
	logic       tick_nxt;

	// free prescaler divider, stopped only while the source is stopped
	always_ff @(posedge sys_clk) begin
		if (rst || clock_source_select == `SCU_CSEL_STOP)
			div_r <= 10'h000;
		else
			div_r <= div_r + 10'h001;
	end

	// two-stage synchroniser then a delayed copy for edge detection
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			pin_meta_r <= 1'b0;
			pin_sync_r <= 1'b0;
			pin_prev_r <= 1'b0;
		end else begin
			pin_meta_r <= ext_pin;
			pin_sync_r <= pin_meta_r;
			pin_prev_r <= pin_sync_r;
		end
	end

	// internal or external source by the select code
	always_comb begin
		case (clock_source_select)
			`SCU_CSEL_STOP:     tick_nxt = 1'b0;
			`SCU_CSEL_DIV1:     tick_nxt = 1'b1;
			`SCU_CSEL_DIV8:     tick_nxt = ((div_r & `SCU_DIV8_LAST) == `SCU_DIV8_LAST); // low bits all ones
			`SCU_CSEL_DIV64:    tick_nxt = ((div_r & `SCU_DIV64_LAST) == `SCU_DIV64_LAST);
			`SCU_CSEL_DIV256:   tick_nxt = ((div_r & `SCU_DIV256_LAST) == `SCU_DIV256_LAST);
			`SCU_CSEL_DIV1024:  tick_nxt = (div_r == `SCU_DIV1024_LAST);
			`SCU_CSEL_EXT_FALL: tick_nxt = pin_prev_r & ~pin_sync_r;
			default:            tick_nxt = ~pin_prev_r & pin_sync_r;
		endcase
	end

	// step enable is a handshake-like strobe, combinational is fine here
	assign count_clock = tick_nxt;

endmodule

`default_nettype wire

// File: rtl/scu_counter_unit.sv
/*
 * sixteen-bit counter unit with byte-wide processor access through a shared
 * high-byte holding register, clock select, mode-driven count sequence and
 * wrap flag. compare and capture words sit behind the same holding register.
 * assumes a processor that issues one-cycle rd or wr strobes on sys_clk and
 * samples rdata in the cycle after a read strobe.
 * assumes rd and wr are never raised together; unmapped indices read as zero
 * and ignore writes.
 * assumes no capture unit drives the capture word, so the host may write it
 * in any mode; compare reads go straight to the word, not through holding.
 * assumes the external count pin is asynchronous to sys_clk.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"

module scu_counter_unit
	import scu_pkg::*;
(
	input  wire logic             sys_clk,
	input  wire logic             rst,
	input  wire scu_bus_req_type  bus_req,
	output logic [7:0]            rdata,
	input  wire logic             ext_pin,
	output logic                  wrap_irq,
	output scu_ind_type           ind,
	output logic [15:0]           count_value
);

	// ****************************************************************
	// state
	// ****************************************************************
	logic [7:0]  timer_control_a_r;
	logic [7:0]  timer_control_b_r;
	logic [7:0]  hold_r;
	logic [15:0] count_r;
	logic [15:0] count_nxt;
	logic [15:0] compare_value_r;
	logic [15:0] capture_value_r;
	logic        down_r;
	logic        wrap_flag_r;
	logic        wrap_set;
	logic [7:0]  rdata_r;
	logic        cnt_write;
	logic        hold_write;
	logic        cnt_read_lo;
	logic        count_clock;
	logic [3:0]  waveform_mode_select;
	logic [15:0] top_value;
	scu_seq_type seq;

	// decodes a bus address against one register index
	function automatic logic hit(input logic [3:0] a, input logic [3:0] idx);
		hit = (a == idx);
	endfunction

	// ****************************************************************
	// bus strobe decode
	// ****************************************************************
	// the low-byte counter write is decoded once because three processes must
	// agree that it drops the step, freezes the turn and blocks the wrap set
	assign cnt_write   = bus_req.wr && hit(bus_req.addr, `SCU_IDX_CNT_LO);
	// every high-byte location lands in the one holding register
	assign hold_write  = bus_req.wr && (hit(bus_req.addr, `SCU_IDX_CNT_HI)
		|| hit(bus_req.addr, `SCU_IDX_CMP_HI) || hit(bus_req.addr, `SCU_IDX_CAP_HI));
	assign cnt_read_lo = bus_req.rd && hit(bus_req.addr, `SCU_IDX_CNT_LO);

	// ****************************************************************
	// count clock and mode decode
	// ****************************************************************
	// the step enable is one cycle wide, so each counting process sees a step once
	scu_clock_select u_clock_select (
		.sys_clk             (sys_clk),
		.rst                 (rst),
		.clock_source_select (timer_control_b_r[`SCU_CSEL_MSB:`SCU_CSEL_LSB]),
		.ext_pin             (ext_pin),
		.count_clock         (count_clock)
	);

	// mode bits 3:2 live in control b, 1:0 in control a
	assign waveform_mode_select = {timer_control_b_r[`SCU_WGM_B_MSB:`SCU_WGM_B_LSB],
		timer_control_a_r[`SCU_WGM_A_MSB:`SCU_WGM_A_LSB]};

	// top value and sequence shape per mode; compare/capture may set top
	// fixed tops of 8, 9 and 10 bits exist in both shapes; code 13 has no
	// sequence of its own and falls back to the free-running wrap, the
	// harmless choice when a stray write selects it
	// a top taken from a word follows host writes at once, with no buffering
	always_comb begin
		top_value = `SCU_MAX;
		seq       = SCU_SEQ_UP_WRAP;
		case (waveform_mode_select)
			4'h1: begin top_value = `SCU_TOP_8BIT;  seq = SCU_SEQ_UP_DOWN; end
			4'h2: begin top_value = `SCU_TOP_9BIT;  seq = SCU_SEQ_UP_DOWN; end
			4'h3: begin top_value = `SCU_TOP_10BIT; seq = SCU_SEQ_UP_DOWN; end
			4'h4: begin top_value = compare_value_r; seq = SCU_SEQ_UP_CLEAR; end
			4'h5: begin top_value = `SCU_TOP_8BIT;  seq = SCU_SEQ_UP_CLEAR; end
			4'h6: begin top_value = `SCU_TOP_9BIT;  seq = SCU_SEQ_UP_CLEAR; end
			4'h7: begin top_value = `SCU_TOP_10BIT; seq = SCU_SEQ_UP_CLEAR; end
			4'h8, 4'ha: begin top_value = capture_value_r; seq = SCU_SEQ_UP_DOWN; end
			4'h9, 4'hb: begin top_value = compare_value_r; seq = SCU_SEQ_UP_DOWN; end
			4'hc: begin top_value = capture_value_r; seq = SCU_SEQ_UP_CLEAR; end
			4'he: begin top_value = capture_value_r; seq = SCU_SEQ_UP_CLEAR; end
			4'hf: begin top_value = compare_value_r; seq = SCU_SEQ_UP_CLEAR; end
			default: begin top_value = `SCU_MAX; seq = SCU_SEQ_UP_WRAP; end
		endcase
	end

	// top and bottom indications from the live count
	// combinational, so a later waveform stage can act in the same cycle as the count
	assign ind.top    = (count_r == top_value);
	assign ind.bottom = (count_r == `SCU_BOTTOM);

	// ****************************************************************
	// next count value
	// ****************************************************************
	// one step per count clock; direction reverses at the sequence ends
	// the turn and the step away from an end happen together, so each end lasts one step
	// the wrap set rides on the step, so a dropped step never raises the flag
	always_comb begin
		count_nxt = count_r;
		wrap_set  = 1'b0;
		if (count_clock) begin
			case (seq)
				SCU_SEQ_UP_CLEAR: begin
					if (ind.top) begin
						count_nxt = `SCU_BOTTOM;
						wrap_set  = (top_value == `SCU_MAX) || waveform_mode_select[0] || waveform_mode_select[1];
					end else
						count_nxt = count_r + `SCU_ONE;
				end
				SCU_SEQ_UP_DOWN: begin
					if (down_r && !ind.bottom)
						count_nxt = count_r - `SCU_ONE;
					else if (!down_r && !ind.top)
						count_nxt = count_r + `SCU_ONE;
					else if (down_r)
						count_nxt = count_r + `SCU_ONE;
					else
						count_nxt = count_r - `SCU_ONE;
					wrap_set = down_r && ind.bottom;
				end
				default: begin
					count_nxt = count_r + `SCU_ONE;
					wrap_set  = (count_r == `SCU_MAX);
				end
			endcase
		end
	end

	// counter register; a processor low-byte write wins over any step
	// the step is dropped, not delayed, so the word lands exactly as written
	always_ff @(posedge sys_clk) begin
		if (rst)
			count_r <= `SCU_RST_WORD;
		else if (cnt_write)
			count_r <= {hold_r, bus_req.wdata};
		else
			count_r <= count_nxt;
	end

	// direction for up-down sequences; turns at top and bottom
	// a counter write freezes the direction, so counting resumes from the written value
	always_ff @(posedge sys_clk) begin
		if (rst)
			down_r <= 1'b0;
		else if (seq != SCU_SEQ_UP_DOWN)
			down_r <= 1'b0;
		else if (count_clock && !cnt_write) begin
			if (ind.top)
				down_r <= 1'b1;
			else if (ind.bottom)
				down_r <= 1'b0;
		end
	end

	// ****************************************************************
	// shared high-byte holding register
	// ****************************************************************
	// a count or capture low-byte read copies that word's upper byte; only those or a high write change it,
	// so one written high byte can feed several low-byte writes
	// compare reads skip it, so a compare read never refreshes the high byte;
	// a host that shares it with interrupt code must fence each pair itself
	always_ff @(posedge sys_clk) begin
		if (rst)
			hold_r <= `SCU_RST_BYTE;
		else if (hold_write)
			hold_r <= bus_req.wdata;
		else if (cnt_read_lo)
			hold_r <= count_r[15:8];
		else if (bus_req.rd && hit(bus_req.addr, `SCU_IDX_CAP_LO))
			hold_r <= capture_value_r[15:8];
	end

	// compare and capture words load whole from the holding register
	// whole-word loads keep a half-updated top from ever reaching the sequence,
	// at the cost of the host always writing the high byte first
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			compare_value_r <= `SCU_RST_WORD;
			capture_value_r <= `SCU_RST_WORD;
		end else begin
			if (bus_req.wr && hit(bus_req.addr, `SCU_IDX_CMP_LO))
				compare_value_r <= {hold_r, bus_req.wdata};
			if (bus_req.wr && hit(bus_req.addr, `SCU_IDX_CAP_LO))
				capture_value_r <= {hold_r, bus_req.wdata};
		end
	end

	// ****************************************************************
	// control registers and wrap flag
	// ****************************************************************
	// control bytes load whole; a new clock select acts from the next edge and
	// leaving stop restarts the divider, so the first prescaled step comes a
	// full period after the start
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			timer_control_a_r <= `SCU_RST_BYTE;
			timer_control_b_r <= `SCU_RST_BYTE;
		end else if (bus_req.wr) begin
			if (hit(bus_req.addr, `SCU_IDX_CTRL_A))
				timer_control_a_r <= bus_req.wdata;
			else if (hit(bus_req.addr, `SCU_IDX_CTRL_B))
				timer_control_b_r <= bus_req.wdata;
		end
	end

	// set wins over a write-one clear in the same cycle; a counter write
	// suppresses the step and therefore the set as well
	// clearing is write-one, so a read-modify-write of other bits clears it if it reads the flag back set
	always_ff @(posedge sys_clk) begin
		if (rst)
			wrap_flag_r <= 1'b0;
		else if (wrap_set && !cnt_write)
			wrap_flag_r <= 1'b1;
		else if (bus_req.wr && hit(bus_req.addr, `SCU_IDX_FLAGS) && bus_req.wdata[`SCU_WRAP_BIT])
			wrap_flag_r <= 1'b0;
	end

	// ****************************************************************
	// outputs
	// ****************************************************************
	// the flag is a plain level, so the host may poll it or wire it to an interrupt
	assign wrap_irq    = wrap_flag_r;
	assign count_value = count_r;

	// ****************************************************************
	// read data
	// ****************************************************************
	// registered read data, valid the cycle after the read strobe
	// unmapped indices read zero so a stray read never returns stale data;
	// the byte then stands until the next read strobe
	always_ff @(posedge sys_clk) begin
		if (rst)
			rdata_r <= `SCU_RST_BYTE;
		else if (bus_req.rd) begin
			if (hit(bus_req.addr, `SCU_IDX_CTRL_A))
				rdata_r <= timer_control_a_r;
			else if (hit(bus_req.addr, `SCU_IDX_CTRL_B))
				rdata_r <= timer_control_b_r;
			else if (hit(bus_req.addr, `SCU_IDX_CNT_LO))
				rdata_r <= count_r[7:0];
			else if (hit(bus_req.addr, `SCU_IDX_CNT_HI) || hit(bus_req.addr, `SCU_IDX_CAP_HI))
				rdata_r <= hold_r;
			else if (hit(bus_req.addr, `SCU_IDX_CMP_LO))
				rdata_r <= compare_value_r[7:0];
			else if (hit(bus_req.addr, `SCU_IDX_CMP_HI))
				rdata_r <= compare_value_r[15:8];
			else if (hit(bus_req.addr, `SCU_IDX_CAP_LO))
				rdata_r <= capture_value_r[7:0];
			else if (hit(bus_req.addr, `SCU_IDX_FLAGS))
				rdata_r <= {7'h00, wrap_flag_r};
			else
				rdata_r <= `SCU_RST_BYTE;
		end
	end

	assign rdata = rdata_r;

endmodule

`default_nettype wire

// File: testbench/scu_host_model.sv
/*
 * host side model: a byte-wide processor issuing one-cycle rd or wr strobes.
 * assumes sys_clk from the bench and the bench calling its tasks in sequence.
 */
`timescale 1ns/1ps
`default_nettype none

module scu_host_model
	import scu_pkg::*;
(
	input  wire logic       sys_clk,
	input  wire logic [7:0] rdata,
	output var scu_bus_req_type bus_req
);
	// idle bus: strobes low, address and data inverted so stale values never pass for live ones
	initial begin
		bus_req = '{addr: 4'hf, rd: 1'b0, wr: 1'b0, wdata: 8'h00};
	end

	// one access: drive just after an edge, hold for the taking edge, then release
	task automatic drive(input logic [3:0] a, input logic r, input logic [7:0] d);
		@(posedge sys_clk);
		#1;
		bus_req = '{addr: a, rd: r, wr: ~r, wdata: d};
		@(posedge sys_clk);
		#1;
		bus_req = '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
	endtask

	task automatic write(input logic [3:0] a, input logic [7:0] d);
		drive(a, 1'b0, d);
	endtask

	// read data is registered on the taking edge, so it is ready on release
	task automatic read(input logic [3:0] a, output logic [7:0] d);
		drive(a, 1'b1, 8'h00);
		d = rdata;
	endtask

	// never split by other traffic, so the shared high byte stays ours
	task automatic write16(input logic [3:0] hi, input logic [3:0] lo, input logic [15:0] v);
		write(hi, v[15:8]);
		write(lo, v[7:0]);
	endtask

	task automatic read16(input logic [3:0] lo, input logic [3:0] hi, output logic [15:0] v);
		read(lo, v[7:0]);
		read(hi, v[15:8]);
	endtask
endmodule

`default_nettype wire

// File: testbench/scu_counter_unit_assertions.sv
/*
 * checker for the counter unit ports: word transfers, stepping and flags.
 * assumes one clock, synchronous active-high reset, bound to the top module.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"

module scu_counter_unit_chk
	import scu_pkg::*;
(
	input wire logic            sys_clk,
	input wire logic            rst,
	input wire scu_bus_req_type bus_req,
	input wire logic [7:0]      rdata,
	input wire logic            ext_pin,
	input wire logic            wrap_irq,
	input wire scu_ind_type     ind,
	input wire logic [15:0]     count_value
);
	default clocking cb @(posedge sys_clk); endclocking

	logic [7:0] hold_r;
	logic       hold_ok_r;
	logic [2:0] csel_r;
	logic [3:0] mode_r;
	logic [2:0] stop_sh_r;
	logic [2:0] run_sh_r;
	wire logic [7:0] cnt_lo = count_value[7:0];
	wire logic  wr_lo = bus_req.wr && bus_req.addr == `SCU_IDX_CNT_LO;
	wire logic  rd_lo = bus_req.rd && bus_req.addr == `SCU_IDX_CNT_LO;
	wire logic  rd_hi = bus_req.rd && bus_req.addr == `SCU_IDX_CNT_HI;
	// no write this cycle that could move the count or its control
	wire logic  quiet = !(bus_req.wr && bus_req.addr <= `SCU_IDX_CNT_LO);

	// shadow of the shared high byte; capture words are not tracked, so a capture read spoils it
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			hold_r    <= `SCU_RST_BYTE;
			hold_ok_r <= 1'b1;
		end else if (bus_req.wr && bus_req.addr[0] && bus_req.addr >= `SCU_IDX_CNT_HI
				&& bus_req.addr <= `SCU_IDX_CAP_HI) begin
			hold_r    <= bus_req.wdata;
			hold_ok_r <= 1'b1;
		end else if (rd_lo) begin
			hold_r <= count_value[15:8];
		end else if (bus_req.rd && bus_req.addr == `SCU_IDX_CAP_LO) begin
			hold_ok_r <= 1'b0;
		end
	end

	// shadow controls plus a short history, so step pipelining never trips a check
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			csel_r    <= `SCU_CSEL_STOP;
			mode_r    <= 4'h0;
			stop_sh_r <= 3'h7;
			run_sh_r  <= 3'h0;
		end else begin
			if (bus_req.wr && bus_req.addr == `SCU_IDX_CTRL_A)
				mode_r[1:0] <= bus_req.wdata[1:0];
			if (bus_req.wr && bus_req.addr == `SCU_IDX_CTRL_B)
				{mode_r[3:2], csel_r} <= bus_req.wdata[4:0];
			stop_sh_r <= {stop_sh_r[1:0], csel_r == `SCU_CSEL_STOP};
			run_sh_r  <= {run_sh_r[1:0], csel_r == `SCU_CSEL_DIV1 && mode_r == 4'h0};
		end
	end

	chk_low_write_load: assert property (disable iff (rst)
		wr_lo && hold_ok_r |=> count_value == {$past(hold_r), $past(bus_req.wdata)})
		else $error("low byte write did not load the full word");
	chk_high_read_hold: assert property (disable iff (rst)
		rd_hi && hold_ok_r |=> rdata == $past(hold_r))
		else $error("high byte read did not return the holding byte");
	chk_low_read_copy: assert property (disable iff (rst)
		rd_lo |=> rdata == $past(cnt_lo))
		else $error("low byte read returned a wrong value");
	chk_stopped_hold: assert property (disable iff (rst)
		stop_sh_r == 3'h7 && csel_r == `SCU_CSEL_STOP && quiet |=> $stable(count_value))
		else $error("counter moved with no clock selected");
	chk_step_by_one: assert property (disable iff (rst)
		run_sh_r == 3'h7 && csel_r == `SCU_CSEL_DIV1 && quiet |=> count_value == $past(count_value) + `SCU_ONE)
		else $error("free count did not step by one");
	chk_wrap_at_max: assert property (disable iff (rst)
		run_sh_r == 3'h7 && quiet && count_value == `SCU_MAX |-> ##[1:2] wrap_irq)
		else $error("wrap flag not raised after max");
	chk_bottom_flag: assert property (disable iff (rst)
		ind.bottom == (count_value == `SCU_BOTTOM))
		else $error("bottom indication wrong");
	chk_top_flag: assert property (disable iff (rst)
		mode_r == 4'h0 |-> ind.top == (count_value == `SCU_MAX))
		else $error("top indication wrong");
	chk_reset_clear: assert property (
		rst |=> count_value == `SCU_RST_WORD && !wrap_irq && rdata == `SCU_RST_BYTE)
		else $error("reset did not clear the unit");

	cover property (wr_lo && hold_ok_r);
	cover property ($rose(wrap_irq));
	cover property (rd_hi);
endmodule

bind scu_counter_unit scu_counter_unit_chk chk_u (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req),
	.rdata(rdata), .ext_pin(ext_pin), .wrap_irq(wrap_irq), .ind(ind), .count_value(count_value));

`default_nettype wire

// File: testbench/tb.sv
/*
 * self-checking bench for the counter unit, driving it through the host model.
 * assumes the checker is bound from its own file.
 */
`timescale 1ns/1ps
`default_nettype none
`include "scu_consts.svh"

module tb;
	import scu_pkg::*;

	logic            sys_clk;
	logic            rst;
	logic            ext_pin;
	scu_bus_req_type bus_req;
	logic [7:0]      rdata;
	logic            wrap_irq;
	scu_ind_type     ind;
	logic [15:0]     count_value;
	logic [15:0]     v;
	logic [7:0]      b;
	int              failures;
	int              checked;

	scu_counter_unit dut_u (.sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
		.ext_pin(ext_pin), .wrap_irq(wrap_irq), .ind(ind), .count_value(count_value));
	scu_host_model host_u (.sys_clk(sys_clk), .rdata(rdata), .bus_req(bus_req));

	// 100 ns period
	initial begin
		sys_clk = 1'b0;
		forever #50 sys_clk = ~sys_clk;
	end

	task automatic check_word(input string what, input logic [15:0] exp, input logic [15:0] got);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", checked, failures);
		if (failures == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	// bounded wait on the count or on the wrap flag; running out ends the run
	task automatic wait_for(input string what, input logic [15:0] exp, input int lim, input bit flag);
		for (int i = 0; i < lim; i++) begin
			if ((flag ? {15'h0000, wrap_irq} : count_value) === exp) begin
				check_word(what, exp, exp);
				return;
			end
			@(posedge sys_clk);
			#1;
		end
		failures++;
		$display("CHECK FAILED %s expected %h seen timeout", what, exp);
		report_and_stop();
	endtask

	// load a start value with the clock stopped, then start in the given mode
	task automatic run_mode(input logic [7:0] ca, input logic [7:0] cb, input logic [15:0] start,
			input logic [15:0] exp);
		host_u.write(`SCU_IDX_CTRL_B, 8'h00);
		host_u.write(`SCU_IDX_CTRL_A, ca);
		host_u.write16(`SCU_IDX_CNT_HI, `SCU_IDX_CNT_LO, start);
		host_u.write(`SCU_IDX_CTRL_B, cb);
		wait_for("count", exp, 40, 1'b0);
	endtask

	// main sequence
	initial begin
		failures = 0;
		checked = 0;
		rst = 1'b1;
		ext_pin = 1'b0;
		repeat (8) @(posedge sys_clk);
		#1 rst = 1'b0;
		host_u.read16(`SCU_IDX_CNT_LO, `SCU_IDX_CNT_HI, v);
		check_word("count after reset", 16'h0000, v);
		host_u.read(4'hf, b);
		check_word("unmapped read", 16'h0000, {8'h00, b});
		$display("test reset done");

		host_u.write16(`SCU_IDX_CNT_HI, `SCU_IDX_CNT_LO, 16'h01ff);
		check_word("stopped write", 16'h01ff, count_value);
		host_u.read16(`SCU_IDX_CNT_LO, `SCU_IDX_CNT_HI, v);
		check_word("stopped read", 16'h01ff, v);
		repeat (5) @(posedge sys_clk);
		#1;
		check_word("stopped hold", 16'h01ff, count_value);
		$display("test stopped access done");

		host_u.write(`SCU_IDX_CNT_HI, 8'hab);
		host_u.write(`SCU_IDX_CNT_LO, 8'h12);
		host_u.write(`SCU_IDX_CAP_LO, 8'h56);
		check_word("shared high count", 16'hab12, count_value);
		host_u.read16(`SCU_IDX_CAP_LO, `SCU_IDX_CAP_HI, v);
		check_word("shared high capture", 16'hab56, v);
		$display("test shared holding done");

		run_mode(8'h00, {5'h00, `SCU_CSEL_DIV1}, 16'hfff8, 16'h0000);
		wait_for("wrap flag", 16'h0001, 3, 1'b1);
		v = count_value;
		@(posedge sys_clk);
		#1;
		check_word("one step", v + 16'h0001, count_value);
		host_u.write16(`SCU_IDX_CNT_HI, `SCU_IDX_CNT_LO, 16'h1234);
		check_word("write beats step", 16'h1234, count_value);
		host_u.write(`SCU_IDX_FLAGS, 8'h01);
		check_word("wrap cleared", 16'h0000, {15'h0000, wrap_irq});
		$display("test running done");

		run_mode(8'h01, 8'h09, 16'h00f0, 16'h0000);
		wait_for("clear wrap flag", 16'h0001, 3, 1'b1);
		run_mode(8'h01, 8'h01, 16'h00fe, 16'h00fc);
		run_mode(8'h00, {5'h00, `SCU_CSEL_DIV8}, 16'h0100, 16'h0102);
		$display("test modes done");

		host_u.write(`SCU_IDX_CTRL_B, 8'h00);
		host_u.write(`SCU_IDX_CTRL_A, 8'h00);
		host_u.write16(`SCU_IDX_CNT_HI, `SCU_IDX_CNT_LO, 16'h0010);
		host_u.write(`SCU_IDX_CTRL_B, {5'h00, `SCU_CSEL_EXT_RISE});
		@(posedge sys_clk);
		#1 ext_pin = 1'b1;
		wait_for("pin step", 16'h0011, 8, 1'b0);
		host_u.write(`SCU_IDX_CTRL_B, 8'h00);
		v = count_value;
		ext_pin = 1'b0;
		repeat (6) @(posedge sys_clk);
		#1;
		check_word("stop after pin", v, count_value);
		ext_pin = 1'b1;
		host_u.write(`SCU_IDX_CTRL_B, {5'h00, `SCU_CSEL_EXT_FALL});
		v = count_value;
		ext_pin = 1'b0;
		wait_for("pin fall step", v + 16'h0001, 8, 1'b0);
		$display("test external pin done");

		host_u.write(`SCU_IDX_CTRL_B, {5'h00, `SCU_CSEL_DIV1});
		rst = 1'b1;
		repeat (2) @(posedge sys_clk);
		#1 rst = 1'b0;
		check_word("count after reset", 16'h0000, count_value);
		host_u.read(`SCU_IDX_CNT_HI, b);
		check_word("holding after reset", 16'h0000, {8'h00, b});
		check_word("stopped after reset", 16'h0000, count_value);
		$display("test second reset done");
		report_and_stop();
	end
endmodule

`default_nettype wire
